// ### logic/pi_loop_regs.sv
// gain and integral-term register bank for the dq current loops
`timescale 1ns/1ps
`default_nettype none

module pi_loop_regs #(
	parameter int ADDR_W = 8
) (
	// clock and reset
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	// register port
	input wire logic [ADDR_W-1:0] reg_addr_in,
	input wire logic [pi_loop_regs_pkg::WORD_W-1:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [pi_loop_regs_pkg::WORD_W-1:0] reg_rdata_out,
	// gains toward the loop arithmetic
	output logic [pi_loop_regs_pkg::GAIN_W-1:0] d_ki_field_out,
	output logic [pi_loop_regs_pkg::GAIN_W-1:0] d_kp_field_out,
	output logic [pi_loop_regs_pkg::GAIN_W-1:0] q_ki_field_out,
	output logic [pi_loop_regs_pkg::GAIN_W-1:0] q_kp_field_out,
	// accumulator write-back from the loop arithmetic
	input wire logic d_accum_load_in,
	input wire logic [pi_loop_regs_pkg::ACC_W-1:0] d_accum_next_in,
	input wire logic q_accum_load_in,
	input wire logic [pi_loop_regs_pkg::ACC_W-1:0] q_accum_next_in,
	// running integrals and preset pulses
	output logic [pi_loop_regs_pkg::ACC_W-1:0] d_integral_accumulator_out,
	output logic [pi_loop_regs_pkg::ACC_W-1:0] q_integral_accumulator_out,
	output logic d_preset_out,
	output logic q_preset_out
);
	import pi_loop_regs_pkg::*;

	// --------------------------------------------------------------
	// parameter check
	// --------------------------------------------------------------
	generate
		if (ADDR_W < REG_ADDR_W) begin : g_bad_addr
			$error("ADDR_W too narrow for the register map");
		end
	endgenerate

	// --------------------------------------------------------------
	// address decode
	// --------------------------------------------------------------
	logic [REG_ADDR_W-1:0] addr_low;
	logic addr_top_zero;
	logic hit_d_ki;
	logic hit_d_kp;
	logic hit_q_ki;
	logic hit_q_kp;
	logic [AXES-1:0] hit_high;
	logic [AXES-1:0] hit_mid;
	logic [AXES-1:0] wr_high;
	logic [AXES-1:0] wr_mid;
	logic [AXES-1:0] load_in;
	logic [ACC_W-1:0] next_in [AXES];
	logic [ACC_W-1:0] accum_q [AXES];
	logic [ACC_W-1:0] accum_d [AXES];
	logic [AXES-1:0] preset_q;

	// split address; upper bits must be zero for any hit
	always_comb begin
		addr_low = reg_addr_in[REG_ADDR_W-1:0];
		addr_top_zero = 1'b1;
		for (int b = REG_ADDR_W; b < ADDR_W; b++) begin
			if (reg_addr_in[b]) begin
				addr_top_zero = 1'b0;
			end
		end
	end

	// register selects
	assign hit_d_ki = addr_top_zero && (addr_low == OFF_D_KI);
	assign hit_d_kp = addr_top_zero && (addr_low == OFF_D_KP);
	assign hit_q_ki = addr_top_zero && (addr_low == OFF_Q_KI);
	assign hit_q_kp = addr_top_zero && (addr_low == OFF_Q_KP);
	assign hit_high[AXIS_D] = addr_top_zero && (addr_low == OFF_D_HIGH);
	assign hit_high[AXIS_Q] = addr_top_zero && (addr_low == OFF_Q_HIGH);
	assign hit_mid[AXIS_D] = addr_top_zero && (addr_low == OFF_D_MID);
	assign hit_mid[AXIS_Q] = addr_top_zero && (addr_low == OFF_Q_MID);
	assign wr_high = hit_high & {AXES{reg_wr_in}};
	assign wr_mid = hit_mid & {AXES{reg_wr_in}};

	// engine write-back gathered per axis
	assign load_in[AXIS_D] = d_accum_load_in;
	assign load_in[AXIS_Q] = q_accum_load_in;
	assign next_in[AXIS_D] = d_accum_next_in;
	assign next_in[AXIS_Q] = q_accum_next_in;

	// --------------------------------------------------------------
	// gain registers
	// --------------------------------------------------------------
	// d integral gain, full 16-bit range
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			d_ki_field_out <= GAIN_RST;
		end else if (reg_wr_in && hit_d_ki) begin
			d_ki_field_out <= reg_wdata_in[GAIN_MSB:0];
		end
	end

	// d proportional gain
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			d_kp_field_out <= GAIN_RST;
		end else if (reg_wr_in && hit_d_kp) begin
			d_kp_field_out <= reg_wdata_in[GAIN_MSB:0];
		end
	end

	// q integral gain
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			q_ki_field_out <= GAIN_RST;
		end else if (reg_wr_in && hit_q_ki) begin
			q_ki_field_out <= reg_wdata_in[GAIN_MSB:0];
		end
	end

	// q proportional gain
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			q_kp_field_out <= GAIN_RST;
		end else if (reg_wr_in && hit_q_kp) begin
			q_kp_field_out <= reg_wdata_in[GAIN_MSB:0];
		end
	end

	// --------------------------------------------------------------
	// integral accumulators, one per axis
	// --------------------------------------------------------------
	generate
		for (genvar i = 0; i < AXES; i++) begin : g_axis
			// software preset overrides engine write-back in one cycle
			always_comb begin
				accum_d[i] = accum_q[i];
				if (load_in[i]) begin
					accum_d[i] = next_in[i];
				end
				if (wr_high[i]) begin
					accum_d[i][HIGH_MSB:HIGH_LSB] = reg_wdata_in;
				end
				if (wr_mid[i]) begin
					accum_d[i][MID_MSB:MID_LSB] = reg_wdata_in[MID_MSB:MID_LSB];
					accum_d[i][LOW_MSB:0] = HALF_ZERO;
				end
			end

			// accumulator store
			always_ff @(posedge sys_clk_in) begin
				if (!rst_n_in) begin
					accum_q[i] <= ACC_RST;
				end else begin
					accum_q[i] <= accum_d[i];
				end
			end

			// one-cycle pulse after any software preset
			always_ff @(posedge sys_clk_in) begin
				if (!rst_n_in) begin
					preset_q[i] <= 1'b0;
				end else begin
					preset_q[i] <= wr_high[i] | wr_mid[i];
				end
			end
		end
	endgenerate

	// outputs taken straight from the stores
	assign d_integral_accumulator_out = accum_q[AXIS_D];
	assign q_integral_accumulator_out = accum_q[AXIS_Q];
	assign d_preset_out = preset_q[AXIS_D];
	assign q_preset_out = preset_q[AXIS_Q];

	// --------------------------------------------------------------
	// read data
	// --------------------------------------------------------------
	// one cycle after the strobe only; unmapped reads return zero
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			reg_rdata_out <= WORD_ZERO;
		end else if (!reg_rd_in || !addr_top_zero) begin
			reg_rdata_out <= WORD_ZERO;
		end else begin
			unique case (addr_low)
				OFF_D_KI: begin
					reg_rdata_out <= {HALF_ZERO, d_ki_field_out};
				end
				OFF_D_KP: begin
					reg_rdata_out <= {HALF_ZERO, d_kp_field_out};
				end
				OFF_Q_KI: begin
					reg_rdata_out <= {HALF_ZERO, q_ki_field_out};
				end
				OFF_Q_KP: begin
					reg_rdata_out <= {HALF_ZERO, q_kp_field_out};
				end
				OFF_D_HIGH: begin
					reg_rdata_out <= accum_q[AXIS_D][HIGH_MSB:HIGH_LSB];
				end
				OFF_D_MID: begin
					reg_rdata_out <= {accum_q[AXIS_D][MID_MSB:MID_LSB], HALF_ZERO};
				end
				OFF_Q_HIGH: begin
					reg_rdata_out <= accum_q[AXIS_Q][HIGH_MSB:HIGH_LSB];
				end
				OFF_Q_MID: begin
					reg_rdata_out <= {accum_q[AXIS_Q][MID_MSB:MID_LSB], HALF_ZERO};
				end
				default: begin
					reg_rdata_out <= WORD_ZERO;
				end
			endcase
		end
	end

	// --------------------------------------------------------------
	// assertions
	// --------------------------------------------------------------
	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (!rst_n_in);

	// gain writes land next cycle
	a_d_ki_write: assert property (
		reg_wr_in && hit_d_ki |=>
			d_ki_field_out == $past(reg_wdata_in[GAIN_MSB:0]))
		else $error("d integral gain not stored");

	a_d_kp_write: assert property (
		reg_wr_in && hit_d_kp |=>
			d_kp_field_out == $past(reg_wdata_in[GAIN_MSB:0]))
		else $error("d proportional gain not stored");

	a_q_ki_write: assert property (
		reg_wr_in && hit_q_ki |=>
			q_ki_field_out == $past(reg_wdata_in[GAIN_MSB:0]))
		else $error("q integral gain not stored");

	a_q_kp_write: assert property (
		reg_wr_in && hit_q_kp |=>
			q_kp_field_out == $past(reg_wdata_in[GAIN_MSB:0]))
		else $error("q proportional gain not stored");

	// gain read words carry zero in the upper half
	a_d_ki_readback: assert property (
		reg_rd_in && hit_d_ki |=>
			reg_rdata_out == {HALF_ZERO, $past(d_ki_field_out)})
		else $error("d integral gain readback wrong");

	a_q_kp_readback: assert property (
		reg_rd_in && hit_q_kp |=>
			reg_rdata_out == {HALF_ZERO, $past(q_kp_field_out)})
		else $error("q proportional gain readback wrong");

	// upper accumulator word written whole
	a_d_high_write: assert property (
		wr_high[AXIS_D] |=>
			d_integral_accumulator_out[HIGH_MSB:HIGH_LSB] ==
			$past(reg_wdata_in))
		else $error("d high word not stored");

	a_d_mid_read: assert property (
		reg_rd_in && hit_mid[AXIS_D] |=>
			reg_rdata_out[LOW_MSB:0] == HALF_ZERO &&
			reg_rdata_out[MID_MSB:MID_LSB] ==
			$past(d_integral_accumulator_out[MID_MSB:MID_LSB]))
		else $error("d mid word readback wrong");

	a_d_mid_write: assert property (
		wr_mid[AXIS_D] |=>
			d_integral_accumulator_out[MID_MSB:MID_LSB] ==
			$past(reg_wdata_in[MID_MSB:MID_LSB]) &&
			d_integral_accumulator_out[LOW_MSB:0] == HALF_ZERO)
		else $error("d mid word not stored");

	a_q_high_read: assert property (
		wr_high[AXIS_Q] ##1 reg_rd_in && hit_high[AXIS_Q] |=>
			reg_rdata_out == $past(reg_wdata_in, 2))
		else $error("q high word write-read mismatch");

	a_q_mid_write: assert property (
		wr_mid[AXIS_Q] |=>
			q_integral_accumulator_out[MID_MSB:MID_LSB] ==
			$past(reg_wdata_in[MID_MSB:MID_LSB]) &&
			q_integral_accumulator_out[LOW_MSB:0] == HALF_ZERO)
		else $error("q mid word not stored");

	a_q_mid_read: assert property (
		reg_rd_in && hit_mid[AXIS_Q] |=>
			reg_rdata_out[LOW_MSB:0] == HALF_ZERO &&
			reg_rdata_out[MID_MSB:MID_LSB] ==
			$past(q_integral_accumulator_out[MID_MSB:MID_LSB]))
		else $error("q mid word readback wrong");

	a_engine_load: assert property (
		d_accum_load_in && !wr_high[AXIS_D] && !wr_mid[AXIS_D] |=>
			d_integral_accumulator_out == $past(d_accum_next_in))
		else $error("d accumulator write-back lost");

	a_accum_hold: assert property (
		!q_accum_load_in && !wr_high[AXIS_Q] && !wr_mid[AXIS_Q] |=>
			$stable(q_integral_accumulator_out))
		else $error("q accumulator changed without cause");

	a_reset_clear: assert property (disable iff (1'b0)
		!rst_n_in |=> d_ki_field_out == GAIN_RST &&
			q_kp_field_out == GAIN_RST &&
			d_integral_accumulator_out == ACC_RST &&
			q_integral_accumulator_out == ACC_RST)
		else $error("fields not cleared by reset");

	a_preset_pulse: assert property (
		wr_high[AXIS_D] || wr_mid[AXIS_D] |=> d_preset_out)
		else $error("d preset pulse missing");

	a_q_preset_pulse: assert property (
		wr_high[AXIS_Q] || wr_mid[AXIS_Q] |=> q_preset_out)
		else $error("q preset pulse missing");

	// main scenarios
	c_high_then_read: cover property (
		wr_high[AXIS_D] ##1 reg_rd_in && hit_high[AXIS_D]);
	c_engine_load: cover property (q_accum_load_in ##1 reg_rd_in);
	c_load_and_preset: cover property (d_accum_load_in && wr_mid[AXIS_D]);
	c_back_to_back: cover property (reg_wr_in ##1 reg_rd_in);
	c_q_mid_then_read: cover property (
		wr_mid[AXIS_Q] ##1 reg_rd_in && hit_mid[AXIS_Q]);

endmodule

`default_nettype wire

// ### logic/pi_loop_regs_pkg.sv
// constants for the current-loop gain and integral register bank
package pi_loop_regs_pkg;

	// --------------------------------------------------------------
	// data widths
	// --------------------------------------------------------------
	localparam int WORD_W = 32;
	localparam int GAIN_W = 16;
	localparam int ACC_W = 64;
	localparam int ACC_FRAC_BITS = 63;
	localparam int REG_ADDR_W = 8;
	localparam int AXES = 2;

	// --------------------------------------------------------------
	// byte offsets of the registers
	// --------------------------------------------------------------
	localparam logic [7:0] OFF_D_KI = 8'h00;
	localparam logic [7:0] OFF_D_KP = 8'h04;
	localparam logic [7:0] OFF_Q_KI = 8'h08;
	localparam logic [7:0] OFF_Q_KP = 8'h0c;
	localparam logic [7:0] OFF_D_HIGH = 8'h10;
	localparam logic [7:0] OFF_D_MID = 8'h14;
	localparam logic [7:0] OFF_Q_HIGH = 8'h18;
	localparam logic [7:0] OFF_Q_MID = 8'h1c;

	// --------------------------------------------------------------
	// field positions
	// --------------------------------------------------------------
	localparam int GAIN_MSB = 15;
	localparam int HIGH_LSB = 32;
	localparam int HIGH_MSB = 63;
	localparam int MID_LSB = 16;
	localparam int MID_MSB = 31;
	localparam int LOW_MSB = 15;
	localparam int AXIS_D = 0;
	localparam int AXIS_Q = 1;

	// --------------------------------------------------------------
	// reset values
	// --------------------------------------------------------------
	localparam logic [15:0] GAIN_RST = 16'h0000;
	localparam logic [63:0] ACC_RST = 64'h0000_0000_0000_0000;
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
	localparam logic [15:0] HALF_ZERO = 16'h0000;

endpackage

// ### testbench/tb_top.sv
// self-checking bench for the current-loop register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import pi_loop_regs_pkg::*;
	// ------------------------------
	// signals and reference state
	// ------------------------------
	logic sys_clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [1:0] ld = 2'b00;
	logic [63:0] nxt [2] = '{64'h0, 64'h0};
	logic [31:0] rdata;
	logic [15:0] gain [4];
	logic [63:0] acc [2];
	logic [1:0] pre;
	logic [15:0] g_m [4] = '{16'h0, 16'h0, 16'h0, 16'h0};
	logic [63:0] acc_m [2] = '{64'h0, 64'h0};
	logic [31:0] seed;
	logic [31:0] w;
	logic [7:0] a;
	int mismatches = 0;
	int comparisons = 0;

	// 200 MHz clock
	always #2.5 sys_clk_in = ~sys_clk_in;

	pi_loop_regs #(.ADDR_W(8)) i_pi_loop_regs (
		.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
		.reg_addr_in(addr), .reg_wdata_in(wdata),
		.reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
		.d_ki_field_out(gain[0]), .d_kp_field_out(gain[1]),
		.q_ki_field_out(gain[2]), .q_kp_field_out(gain[3]),
		.d_accum_load_in(ld[0]), .d_accum_next_in(nxt[0]),
		.q_accum_load_in(ld[1]), .q_accum_next_in(nxt[1]),
		.d_integral_accumulator_out(acc[0]),
		.q_integral_accumulator_out(acc[1]),
		.d_preset_out(pre[0]), .q_preset_out(pre[1])
	);

	// ------------------------------
	// compare tasks and expectations
	// ------------------------------
	task automatic miss(string n, logic [63:0] e, logic [63:0] g);
		comparisons++;
		if (g !== e) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic chk_word(string n, logic [31:0] e, logic [31:0] g);
		miss(n, {32'h0, e}, {32'h0, g});
	endtask
	task automatic chk_gain(string n, logic [15:0] e, logic [15:0] g);
		miss(n, {48'h0, e}, {48'h0, g});
	endtask
	task automatic chk_acc(string n, logic [63:0] e, logic [63:0] g);
		miss(n, e, g);
	endtask
	task automatic chk_bit(string n, logic e, logic g);
		miss(n, {63'h0, e}, {63'h0, g});
	endtask

	// galois shift register for random draws
	function automatic logic [31:0] lfsr(logic [31:0] x);
		return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
	endfunction

	// expected read word from the reference state
	function automatic logic [31:0] view(logic [7:0] ad);
		case (ad)
			OFF_D_KI, OFF_D_KP, OFF_Q_KI, OFF_Q_KP: return {HALF_ZERO, g_m[ad[3:2]]};
			OFF_D_HIGH, OFF_Q_HIGH: return acc_m[ad[3]][63:32];
			OFF_D_MID, OFF_Q_MID: return {acc_m[ad[3]][31:16], HALF_ZERO};
			default: return WORD_ZERO;
		endcase
	endfunction

	task automatic check_outs;
		chk_gain("d_ki", g_m[0], gain[0]);
		chk_gain("d_kp", g_m[1], gain[1]);
		chk_gain("q_ki", g_m[2], gain[2]);
		chk_gain("q_kp", g_m[3], gain[3]);
		chk_acc("d_acc", acc_m[0], acc[0]);
		chk_acc("q_acc", acc_m[1], acc[1]);
	endtask

	// ------------------------------
	// bus cycles
	// ------------------------------
	// one clock: every input set once, the next edge's results checked;
	// calls follow each other with no gap, so strobes run back to back
	task automatic step(logic w_s, logic r_s, logic [7:0] ad,
		logic [31:0] wd, logic [1:0] l_s, logic [63:0] n_s);
		logic [1:0] p;
		logic [31:0] e_rd;
		p = 2'b00;
		e_rd = r_s ? view(ad) : WORD_ZERO;
		addr <= ad;
		wdata <= wd;
		wr <= w_s;
		rd <= r_s;
		ld <= l_s;
		nxt[0] <= n_s;
		nxt[1] <= n_s;
		@(posedge sys_clk_in);
		// engine load first, a software word write wins over it
		for (int x = 0; x < 2; x++) if (l_s[x]) acc_m[x] = n_s;
		if (w_s && ad[1:0] == 2'b00 && ad < OFF_D_HIGH)
			g_m[ad[3:2]] = wd[15:0];
		else if (w_s && ad[1:0] == 2'b00 && ad <= OFF_Q_MID) begin
			p[ad[3]] = 1'b1;
			if (ad[2]) acc_m[ad[3]][31:0] = {wd[31:16], HALF_ZERO};
			else acc_m[ad[3]][63:32] = wd;
		end
		#1;
		check_outs;
		chk_bit("d_preset", p[0], pre[0]);
		chk_bit("q_preset", p[1], pre[1]);
		// read data stand in the cycle after the strobe only
		chk_word("rd", e_rd, rdata);
	endtask

	task automatic reg_wr(logic [7:0] ad, logic [31:0] wd);
		step(1'b1, 1'b0, ad, wd, 2'b00, 64'h0);
	endtask

	task automatic reg_rd(logic [7:0] ad);
		step(1'b0, 1'b1, ad, 32'h0, 2'b00, 64'h0);
	endtask

	task automatic idle;
		step(1'b0, 1'b0, 8'h00, 32'h0, 2'b00, 64'h0);
	endtask

	task automatic eng_ld(int ax, logic [63:0] n);
		step(1'b0, 1'b0, 8'h00, 32'h0, ax ? 2'b10 : 2'b01, n);
		reg_rd(ax ? OFF_Q_HIGH : OFF_D_HIGH);
		reg_rd(ax ? OFF_Q_MID : OFF_D_MID);
	endtask

	task automatic conclude;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// ------------------------------
	// test sequence
	// ------------------------------
	initial begin
		seed = 32'h2999c88b;
		repeat (2) @(posedge sys_clk_in);
		rst_n_in <= 1'b1;
		for (int i = 0; i < 8; i++) reg_rd(8'(4 * i));
		idle;
		$display("test reset values done");
		for (int k = 0; k < 48; k++) begin
			seed = lfsr(seed);
			a = {3'b000, seed[4:2], 2'b00};
			seed = lfsr(seed);
			w = (k < 8) ? 32'hffffffff : seed;
			if (k < 8) a = 8'(4 * k);
			reg_wr(a, w);
			reg_rd(a);
		end
		idle;
		$display("test random writes done");
		eng_ld(0, 64'h8000_0000_0000_0000);
		eng_ld(1, 64'h7fff_ffff_ffff_ffff);
		seed = lfsr(seed);
		w = lfsr(seed);
		eng_ld(0, {seed, w});
		reg_wr(OFF_D_MID, 32'h1234_5678);
		reg_rd(OFF_D_MID);
		// engine load and software mid write in the same cycle
		step(1'b1, 1'b0, OFF_D_MID, 32'hfedc_ba98, 2'b01,
			64'h0123_4567_89ab_cdef);
		reg_rd(OFF_D_MID);
		reg_rd(OFF_D_HIGH);
		idle;
		$display("test engine load done");
		reg_wr(8'h20, 32'hffffffff);
		reg_wr(8'hfc, 32'hffffffff);
		reg_rd(8'h20);
		reg_rd(8'hfc);
		idle;
		$display("test unmapped done");
		@(posedge sys_clk_in);
		rst_n_in <= 1'b0;
		repeat (2) @(posedge sys_clk_in);
		rst_n_in <= 1'b1;
		g_m = '{16'h0, 16'h0, 16'h0, 16'h0};
		acc_m = '{64'h0, 64'h0};
		#1;
		check_outs;
		chk_word("reset rd", WORD_ZERO, rdata);
		for (int i = 0; i < 8; i++) reg_rd(8'(4 * i));
		idle;
		$display("test second reset done");
		conclude;
	end

	// watchdog against a hang: about seven times the expected run length
	initial begin
		repeat (1000) @(posedge sys_clk_in);
		mismatches++;
		conclude;
	end
endmodule
`default_nettype wire
